// ===== ixe_pkg.sv
// Package for the instruction execution subset: encodings, layouts, types.
// Assumes a 12-bit instruction word, 8-bit data and a 32-entry file space.
// Notes on behaviour
// RQ1 - Clear writes zero to file, sets zero flag
// RQ2 - Destination bit zero selects accumulator, one file
// RQ3 - Complement inverts operand, updates zero flag
// RQ4 - Decrement subtracts one, updates zero flag
// RQ5 - Decrement-skip stores result, skips on zero
// RQ6 - Taken skip discards prefetched word, two cycles
// RQ7 - Jump loads nine bits, page from status
// RQ8 - Jump takes two cycles, flags untouched
// RQ9 - Increment adds one, updates zero flag
// RQ10 - Increment-skip stores result, skips on wrap
// RQ11 - OR immediate into accumulator, updates zero
// RQ12 - Zero flag reflects eight-bit result, wraps
package ixe_pkg;
    localparam int IW = 12;
    localparam int DW = 8;
    localparam int AW = 5;
    localparam int PW = 11;
    localparam int DEST_BIT = 5;
    localparam int LIT_MSB = 7;
    localparam int JMP_MSB = 8;
    localparam int STAT_PG_HI = 6;
    localparam int STAT_PG_LO = 5;
    localparam logic [6:0] ENC_CLR = 7'h03;
    localparam logic [5:0] ENC_COM = 6'h09;
    localparam logic [5:0] ENC_DEC = 6'h03;
    localparam logic [5:0] ENC_DSZ = 6'h0B;
    localparam logic [5:0] ENC_INC = 6'h0A;
    localparam logic [5:0] ENC_ISZ = 6'h0F;
    localparam logic [2:0] ENC_JMP = 3'h5;
    localparam logic [3:0] ENC_IOR = 4'hD;
    localparam logic [DW-1:0] ACC_RST = 8'h00;
    localparam logic [PW-1:0] PC_RST = 11'h000;
    localparam logic [DW-1:0] ONE = 8'h01;
    localparam logic [DW-1:0] NULL_BYTE = 8'h00;

    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_CLR = 4'b0001,
        OP_COM = 4'b0010,
        OP_DEC = 4'b0011,
        OP_DSZ = 4'b0100,
        OP_INC = 4'b0101,
        OP_ISZ = 4'b0110,
        OP_JMP = 4'b0111,
        OP_IOR = 4'b1000
    } ixe_op_t;

    typedef struct packed {
        logic valid;
        logic [IW-1:0] word;
        logic [DW-1:0] fdata;
    } ixe_pkt_t;

    typedef struct packed {
        logic we;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } ixe_wr_t;

    function automatic ixe_op_t ixe_decode(input logic [IW-1:0] w);
        ixe_op_t op;
        op = OP_NONE;
        if (w[11:5] == ENC_CLR) op = OP_CLR;
        else if (w[11:6] == ENC_COM) op = OP_COM;
        else if (w[11:6] == ENC_DEC) op = OP_DEC;
        else if (w[11:6] == ENC_DSZ) op = OP_DSZ;
        else if (w[11:6] == ENC_INC) op = OP_INC;
        else if (w[11:6] == ENC_ISZ) op = OP_ISZ;
        else if (w[11:9] == ENC_JMP) op = OP_JMP;
        else if (w[11:8] == ENC_IOR) op = OP_IOR;
        return op;
    endfunction
endpackage

// ===== ixe_alu.sv
// Result path for the execution subset.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/10ps
module ixe_alu
    import ixe_pkg::*;
(
    input wire ixe_op_t i_op, // Decoded operation
    input wire logic [DW-1:0] i_fdata, // File operand
    input wire logic [DW-1:0] i_acc, // Accumulator
    input wire logic [DW-1:0] i_lit, // Immediate literal
    output logic [DW-1:0] o_res, // Result
    output logic o_zero // Result is zero
);
    always_comb begin
        case (i_op)
            OP_CLR: o_res = NULL_BYTE; // [RQ1]
            OP_COM: o_res = ~i_fdata; // [RQ3]
            OP_DEC, OP_DSZ: o_res = i_fdata - ONE; // [RQ4] [RQ5] [RQ12]
            OP_INC, OP_ISZ: o_res = i_fdata + ONE; // [RQ9] [RQ10] [RQ12]
            OP_IOR: o_res = i_acc | i_lit; // [RQ11]
            default: o_res = NULL_BYTE;
        endcase
        o_zero = (o_res == NULL_BYTE); // [RQ12]
    end
endmodule

// ===== ixe_core.sv
// Execution stage for clear, complement, increment/decrement (with skip),
// absolute jump and OR-immediate. Core supplies the fetched word with
// its file operand already read; results leave as registered strobes.
`timescale 1ns/10ps
module ixe_core
    import ixe_pkg::*;
(
    input wire logic i_clk, // Instruction clock
    input wire logic i_rstn, // Async reset, active low
    input wire ixe_pkt_t i_pkt, // Fetched word and operand
    input wire logic [DW-1:0] i_status, // Status register
    output ixe_wr_t o_wr, // File register write strobe
    output logic [DW-1:0] o_acc, // Accumulator
    output logic o_zero, // Zero flag
    output logic o_pc_load, // Program counter load pulse
    output logic [PW-1:0] o_pc, // Program counter target
    output logic o_discard // Prefetched word dropped
);
    ixe_op_t op;
    logic [DW-1:0] res;
    logic res_zero;
    logic exec;
    logic dest_file;
    logic skip_r;
    logic skip_nxt;

    assign op = ixe_decode(i_pkt.word);
    // Word arriving behind a taken skip or jump executes as a no-op
    assign exec = i_pkt.valid && !skip_r; // [RQ6]
    assign dest_file = i_pkt.word[DEST_BIT];
    assign skip_nxt = exec && (((op == OP_DSZ) || (op == OP_ISZ)) && res_zero
        || (op == OP_JMP)); // [RQ5] [RQ10] [RQ8]

    ixe_alu i_ixe_alu (
        .i_op(op),
        .i_fdata(i_pkt.fdata),
        .i_acc(o_acc),
        .i_lit(i_pkt.word[LIT_MSB:0]),
        .o_res(res),
        .o_zero(res_zero)
    );

    // Skip pending: cleared only by the next valid word, the one dropped
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            skip_r <= 1'b0;
        end else if (i_pkt.valid) begin
            skip_r <= skip_nxt; // [RQ6]
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_discard <= 1'b0;
        end else begin
            o_discard <= i_pkt.valid && skip_r; // [RQ6]
        end
    end

    // File write: clear always targets the file, complement and inc/dec (with skip) by the dest bit; OR and jump never write
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wr <= '0;
        end else begin
            o_wr.addr <= i_pkt.word[AW-1:0];
            o_wr.data <= res;
            case (op)
                OP_CLR: o_wr.we <= exec; // [RQ1]
                OP_COM, OP_DEC, OP_DSZ, OP_INC, OP_ISZ:
                    o_wr.we <= exec && dest_file; // [RQ2]
                default: o_wr.we <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_acc <= ACC_RST;
        end else if (exec) begin
            case (op)
                OP_COM, OP_DEC, OP_DSZ, OP_INC, OP_ISZ: begin
                    if (!dest_file) begin
                        o_acc <= res; // [RQ2]
                    end
                end
                OP_IOR: o_acc <= res; // [RQ11]
                default: o_acc <= o_acc;
            endcase
        end
    end

    // Skip variants and the jump leave the flag alone
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_zero <= 1'b0;
        end else if (exec) begin
            case (op)
                OP_CLR: o_zero <= 1'b1; // [RQ1]
                OP_COM, OP_DEC, OP_INC, OP_IOR:
                    o_zero <= res_zero; // [RQ3] [RQ4] [RQ9] [RQ11] [RQ12]
                default: o_zero <= o_zero; // [RQ5] [RQ8] [RQ10]
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pc_load <= 1'b0;
            o_pc <= PC_RST;
        end else begin
            o_pc_load <= exec && (op == OP_JMP); // [RQ7]
            if (exec && (op == OP_JMP)) begin
                o_pc <= {i_status[STAT_PG_HI:STAT_PG_LO],
                    i_pkt.word[JMP_MSB:0]}; // [RQ7] [RQ8]
            end
        end
    end

    AST_CLEAR: assert property ( // [RQ1]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_CLR |=> o_wr.we && o_wr.data == 8'h00 && o_zero)
        else $error("clear did not write zero and set flag");

    AST_DEST_ACC: assert property ( // [RQ2]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_COM && !dest_file
        |=> !o_wr.we && o_acc == ~$past(i_pkt.fdata))
        else $error("dest zero did not route to accumulator");

    AST_DEST_FILE: assert property ( // [RQ2]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_DEC && dest_file
        |=> o_wr.we && o_wr.addr == $past(i_pkt.word[4:0]) && $stable(o_acc))
        else $error("dest one did not write the file register");

    AST_COMPLEMENT: assert property ( // [RQ3]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_COM && dest_file
        |=> o_wr.we && o_wr.data == ~$past(i_pkt.fdata)
            && o_zero == ($past(i_pkt.fdata) == 8'hFF))
        else $error("complement result or flag wrong");

    AST_DECREMENT: assert property ( // [RQ4]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_DEC && dest_file
        |=> o_wr.data == $past(i_pkt.fdata) - 8'h01
            && o_zero == ($past(i_pkt.fdata) == 8'h01))
        else $error("decrement result or flag wrong");

    AST_DSZ_FLAG: assert property ( // [RQ5]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_DSZ |=> $stable(o_zero))
        else $error("decrement-skip changed zero flag");

    AST_DSZ_SKIP: assert property ( // [RQ5]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_DSZ |=> skip_r == ($past(i_pkt.fdata) == 8'h01))
        else $error("decrement-skip skip decision wrong");

    AST_SKIP_DROP: assert property ( // [RQ6]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_ISZ && i_pkt.fdata == 8'hFF ##1 i_pkt.valid
        |=> o_discard && !o_wr.we && !o_pc_load)
        else $error("taken skip did not drop next word");

    AST_DROP_HOLD: assert property ( // [RQ6]
        @(posedge i_clk) disable iff (!i_rstn)
        i_pkt.valid && skip_r
        |=> o_discard && !o_wr.we && !o_pc_load && !skip_r
            && $stable(o_acc) && $stable(o_zero))
        else $error("dropped word changed state");

    AST_IDLE: assert property ( // [RQ6]
        @(posedge i_clk) disable iff (!i_rstn)
        !i_pkt.valid |=> !o_wr.we && !o_pc_load && !o_discard)
        else $error("strobe raised without a word");

    AST_JUMP: assert property ( // [RQ7]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_JMP
        |=> o_pc_load && o_pc[8:0] == $past(i_pkt.word[8:0])
            && o_pc[10:9] == $past(i_status[6:5]))
        else $error("jump target wrong");

    AST_JUMP_TWO: assert property ( // [RQ8]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_JMP ##1 i_pkt.valid
        |=> o_discard && $stable(o_zero) && !o_pc_load)
        else $error("jump not two cycles or flag touched");

    AST_JUMP_FLAGS: assert property ( // [RQ8]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_JMP
        |=> $stable(o_zero) && $stable(o_acc) && !o_wr.we && skip_r)
        else $error("jump touched state or did not drop");

    AST_INCREMENT: assert property ( // [RQ9]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_INC && !dest_file
        |=> o_acc == $past(i_pkt.fdata) + 8'h01
            && o_zero == ($past(i_pkt.fdata) == 8'hFF))
        else $error("increment result or flag wrong");

    AST_INC_FILE: assert property ( // [RQ9]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_INC && dest_file
        |=> o_wr.we && o_wr.data == $past(i_pkt.fdata) + 8'h01
            && o_zero == ($past(i_pkt.fdata) == 8'hFF))
        else $error("increment to file wrong");

    AST_ISZ_FLAG: assert property ( // [RQ10]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_ISZ |=> $stable(o_zero))
        else $error("increment-skip changed zero flag");

    AST_ISZ_SKIP: assert property ( // [RQ10]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_ISZ |=> skip_r == ($past(i_pkt.fdata) == 8'hFF))
        else $error("increment-skip skip decision wrong");

    AST_ISZ_RESULT: assert property ( // [RQ10]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_ISZ && !dest_file
        |=> o_acc == $past(i_pkt.fdata) + 8'h01 && !o_wr.we)
        else $error("increment-skip result wrong");

    AST_ORLIT: assert property ( // [RQ11]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_IOR
        |=> o_acc == ($past(o_acc) | $past(i_pkt.word[7:0]))
            && o_zero == (o_acc == 8'h00) && !o_wr.we)
        else $error("OR immediate result or flag wrong");

    AST_ZERO_DEC: assert property ( // [RQ12]
        @(posedge i_clk) disable iff (!i_rstn)
        exec && op == OP_DEC && !dest_file
        |=> o_acc == $past(i_pkt.fdata) - 8'h01
            && o_zero == ($past(i_pkt.fdata) == 8'h01))
        else $error("zero flag does not follow wrapped result");
endmodule

// ===== test_mcu_instruction_exec_subset.sv
// Bench for ixe_core: drives words, models the results, checks outputs.
// Assumes one word a cycle and every answer one edge after the word.
`timescale 1ns/10ps
module test_mcu_instruction_exec_subset;
    import ixe_pkg::*;
    typedef struct packed {
        ixe_wr_t wr;
        logic [DW-1:0] acc;
        logic zero;
        logic pl;
        logic [PW-1:0] pc;
        logic disc;
    } ixe_note_t;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    ixe_pkt_t i_pkt = '0;
    logic [DW-1:0] i_status = 8'h00;
    ixe_wr_t o_wr;
    logic [DW-1:0] o_acc;
    logic o_zero, o_pc_load, o_discard;
    logic [PW-1:0] o_pc;
    ixe_note_t notes[$];
    ixe_note_t m, pend, e;
    logic m_skip = 1'b0;
    logic have_pend = 1'b0;
    logic [15:0] rnd = 16'hA247;
    logic [IW-1:0] w;
    int miscompares = 0;
    int checks = 0;
    always #5 i_clk = ~i_clk;
    ixe_core i_ixe_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_pkt(i_pkt),
        .i_status(i_status), .o_wr(o_wr), .o_acc(o_acc), .o_zero(o_zero),
        .o_pc_load(o_pc_load), .o_pc(o_pc), .o_discard(o_discard));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic fail(input string msg);
        miscompares++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask
    task automatic chk_wr(input ixe_wr_t g, input ixe_wr_t x);
        checks++;
        if (g.we !== x.we || (x.we && g !== x)) fail("file write");
    endtask
    task automatic chk_acc(input logic [DW-1:0] g, input logic gz,
        input ixe_note_t x);
        checks++;
        if (g !== x.acc || gz !== x.zero) fail("acc or zero flag");
    endtask
    task automatic chk_flow(input logic gl, input logic gd,
        input logic [PW-1:0] g, input ixe_note_t x);
        checks++;
        if (gl !== x.pl || gd !== x.disc || g !== x.pc) fail("pc or drop");
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Note is queued one edge late, so the monitor never pops it early
    task automatic issue(input logic v, input logic [IW-1:0] iw,
        input logic [DW-1:0] fd);
        logic [DW-1:0] r;
        logic hasd, zf;
        @(posedge i_clk);
        #1;
        if (have_pend) notes.push_back(pend);
        have_pend = v;
        rnd = lfsr(rnd);
        i_status = rnd[7:0];
        i_pkt = '{v, iw, fd};
        {m.wr.we, m.pl, m.disc, hasd, zf, r} = '0;
        if (!v) return;
        if (m_skip) begin
            m.disc = 1'b1;
            m_skip = 1'b0;
        end else begin
            casez (iw)
                12'b0000011?????: begin
                    m.wr = '{1'b1, iw[4:0], NULL_BYTE};
                    m.zero = 1'b1;
                end
                12'b001001??????: {r, hasd, zf} = {~fd, 2'b11};
                12'b000011??????: {r, hasd, zf} = {fd - ONE, 2'b11};
                12'b001010??????: {r, hasd, zf} = {fd + ONE, 2'b11};
                12'b001011??????: {r, hasd} = {fd - ONE, 1'b1};
                12'b001111??????: {r, hasd} = {fd + ONE, 1'b1};
                12'b101?????????: begin
                    m.pc = {i_status[6:5], iw[8:0]};
                    m.pl = 1'b1;
                    m_skip = 1'b1;
                end
                12'b1101????????: begin
                    m.acc = m.acc | iw[7:0];
                    m.zero = (m.acc == 8'h00);
                end
                default: ;
            endcase
            if (hasd && iw[5]) m.wr = '{1'b1, iw[4:0], r};
            if (hasd && !iw[5]) m.acc = r;
            if (zf) m.zero = (r == 8'h00);
            if (hasd && !zf) m_skip = (r == 8'h00);
        end
        pend = m;
    endtask
    initial begin
        repeat (2000) begin
            @(posedge i_clk);
            #2;
            if (notes.size() > 0) begin
                e = notes.pop_front();
                chk_wr(o_wr, e.wr);
                chk_acc(o_acc, o_zero, e);
                chk_flow(o_pc_load, o_discard, o_pc, e);
            end
        end
    end
    initial begin
        repeat (3000) @(posedge i_clk);
        fail("timeout");
        stop_test();
    end
    initial begin
        m = '0;
        repeat (3) @(posedge i_clk);
        #1;
        chk_wr(o_wr, m.wr);
        chk_acc(o_acc, o_zero, m);
        chk_flow(o_pc_load, o_discard, o_pc, m);
        i_rstn = 1'b1;
        for (int i = 0; i < 72; i++) begin
            rnd = lfsr(rnd);
            case (i % 9)
                0: w = {ENC_CLR, rnd[4:0]};
                1: w = {ENC_COM, rnd[5:0]};
                2: w = {ENC_DEC, rnd[5:0]};
                3: w = {ENC_DSZ, rnd[5:0]};
                4: w = {ENC_INC, rnd[5:0]};
                5: w = {ENC_ISZ, rnd[5:0]};
                6: w = {ENC_JMP, rnd[8:0]};
                // Filler eaten by the jump, so the OR word really runs
                7: w = 12'h000;
                default: w = {ENC_IOR, rnd[7:0]};
            endcase
            issue(1'b1, w, rnd[15:8]);
        end
        issue(1'b1, {ENC_ISZ, 6'h23}, 8'hFF);
        issue(1'b1, {ENC_CLR, 5'h01}, 8'h55);
        issue(1'b1, {ENC_DSZ, 6'h04}, 8'h01);
        issue(1'b0, 12'h000, 8'h00);
        issue(1'b1, {ENC_IOR, 8'hFF}, 8'h00);
        issue(1'b1, {ENC_ISZ, 6'h04}, 8'hFE);
        issue(1'b1, {ENC_JMP, 9'h1FF}, 8'h00);
        issue(1'b1, {ENC_JMP, 9'h000}, 8'h00);
        issue(1'b1, {ENC_JMP, 9'h000}, 8'h00);
        issue(1'b1, 12'h000, 8'h00);
        issue(1'b1, {ENC_INC, 6'h00}, 8'hFF);
        issue(1'b1, {ENC_IOR, 8'h00}, 8'h00);
        issue(1'b1, {ENC_DEC, 6'h3F}, 8'h00);
        issue(1'b1, {ENC_COM, 6'h00}, 8'hFF);
        issue(1'b1, 12'h000, 8'h12);
        issue(1'b0, 12'h000, 8'h00);
        issue(1'b0, 12'h000, 8'h00);
        @(posedge i_clk);
        #3;
        stop_test();
    end
endmodule
